// File: verilog/ebpm_defines.vh
// Purpose: Shared constants of the external bus pin multiplexer
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes:   Definitions only
`ifndef EBPM_DEFINES_VH
`define EBPM_DEFINES_VH

`define EBPM_MODE_NORMAL     2'b00
`define EBPM_MODE_EXPANDED   2'b01
`define EBPM_MODE_EMULATION  2'b10

`define EBPM_ADDR_W          6
`define EBPM_OFF_DATA_A      6'h00
`define EBPM_OFF_DIR_A       6'h04
`define EBPM_OFF_DATA_B      6'h08
`define EBPM_OFF_DIR_B       6'h0c
`define EBPM_OFF_DATA_C      6'h10
`define EBPM_OFF_DIR_C       6'h14
`define EBPM_OFF_DATA_D      6'h18
`define EBPM_OFF_DIR_D       6'h1c
`define EBPM_OFF_E7_CTRL     6'h20
`define EBPM_OFF_THRESH      6'h24
`define EBPM_OFF_STATUS      6'h28

`define EBPM_E7_OUT_BIT      0
`define EBPM_E7_DIR_BIT      1
`define EBPM_E7_CLKEN_BIT    2
`define EBPM_E7_UDSSEL_BIT   3
`define EBPM_E7_PIN_BIT      4

`define EBPM_THR_C_BIT       0
`define EBPM_THR_D_BIT       1
`define EBPM_THR_REDUCED     2'b11
`define EBPM_THR_FULL        2'b00

`define EBPM_RST_DATA        8'h00
`define EBPM_RST_DIR         8'h00
`define EBPM_RST_E7_CTRL     4'h0
`define EBPM_RST_THRESH      2'b00

`define EBPM_INIT_LATCH      2'h3

`endif

// File: verilog/ebpm_sync2.v
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module ebpm_sync2 #(
    parameter W = 33
) (
    input  wire         clk,
    input  wire         nrst,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    assign dout = sync_reg;
endmodule

// File: verilog/ebpm_pin_mux.v
// Purpose: Pin function multiplexer for ports A to D and port E pin 7
// Assumes: clk runs at four times the bus rate; core bus signals share clk
// Notes:   Pin outputs are registered, one clk behind the core signals
`timescale 1ns/1ps
`include "ebpm_defines.vh"
module ebpm_pin_mux (
    input  wire                   clk,
    input  wire                   nrst,
    input  wire [`EBPM_ADDR_W-1:0] avs_address,
    input  wire                   avs_read,
    input  wire                   avs_write,
    input  wire [31:0]            avs_writedata,
    input  wire [3:0]             avs_byteenable,
    output reg  [31:0]            avs_readdata,
    output wire                   avs_waitrequest,
    input  wire [1:0]             mcu_mode,
    input  wire [15:0]            ext_bus_addr,
    input  wire [15:0]            ext_bus_wdata,
    input  wire                   ext_bus_write,
    input  wire                   upper_data_strobe_n,
    input  wire [15:0]            visibility_read_data,
    input  wire                   visibility_phase,
    output wire [15:0]            ext_bus_rdata,
    input  wire [7:0]             port_a_pins_in,
    output reg  [7:0]             port_a_pins_out,
    output reg  [7:0]             port_a_pins_oe_n,
    input  wire [7:0]             port_b_pins_in,
    output reg  [7:0]             port_b_pins_out,
    output reg  [7:0]             port_b_pins_oe_n,
    input  wire [7:0]             port_c_pins_in,
    output reg  [7:0]             port_c_pins_out,
    output reg  [7:0]             port_c_pins_oe_n,
    input  wire [7:0]             port_d_pins_in,
    output reg  [7:0]             port_d_pins_out,
    output reg  [7:0]             port_d_pins_oe_n,
    input  wire                   port_e_pin7_in,
    output reg                    port_e_pin7_out,
    output reg                    port_e_pin7_oe_n,
    output reg                    port_e_pin7_pullup,
    output wire                   port_c_low_thresh,
    output wire                   port_d_low_thresh,
    output reg                    oscillator_select_input
);

    function is_bus_mode;
        input [1:0] m;
        begin
            is_bus_mode = (m == `EBPM_MODE_EXPANDED) || (m == `EBPM_MODE_EMULATION);
        end
    endfunction

    function [7:0] gpio_view;
        input [7:0] dout;
        input [7:0] dir;
        input [7:0] pin;
        begin
            gpio_view = (dout & dir) | (pin & ~dir);
        end
    endfunction

    wire [32:0] pins_sync;
    wire [31:0] pin_vec;
    wire        e7_sync;

    ebpm_sync2 #(.W(33)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  ({port_e_pin7_in, port_d_pins_in, port_c_pins_in, port_b_pins_in, port_a_pins_in}),
        .dout (pins_sync)
    );
    assign pin_vec = pins_sync[31:0];
    assign e7_sync = pins_sync[32];

    wire [31:0] dout_reg;
    wire [31:0] dir_reg;
    reg [3:0]  e7_ctrl_reg;
    reg [1:0]  thresh_reg;
    reg [1:0]  init_cnt_reg;
    reg        init_done_reg;
    reg        dclk_reg;
    reg        ack_reg;

    wire bus_mode  = is_bus_mode(mcu_mode);
    wire emul_mode = (mcu_mode == `EBPM_MODE_EMULATION);
    wire vis_now   = emul_mode & visibility_phase;
    wire wr_go     = avs_write & ack_reg & avs_byteenable[0];

    // Single wait state: request taken, answered one edge later
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_port_regs
            // Each port owns its byte, so every slice has one driver
            reg [7:0] port_dout_reg;
            reg [7:0] port_dir_reg;
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    port_dout_reg <= `EBPM_RST_DATA;
                    port_dir_reg  <= `EBPM_RST_DIR;
                end else if (wr_go) begin
                    if ({26'h0, avs_address} == gi * 8) begin
                        port_dout_reg <= avs_writedata[7:0];
                    end else if ({26'h0, avs_address} == gi * 8 + 4) begin
                        port_dir_reg <= avs_writedata[7:0];
                    end
                end
            end
            assign dout_reg[gi*8 +: 8] = port_dout_reg;
            assign dir_reg[gi*8 +: 8]  = port_dir_reg;
        end
    endgenerate

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            e7_ctrl_reg <= `EBPM_RST_E7_CTRL;
        end else if (wr_go && avs_address == `EBPM_OFF_E7_CTRL) begin
            e7_ctrl_reg <= avs_writedata[3:0];
        end
    end

    // Threshold default depends on mode, so it loads after release, not in reset
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            thresh_reg <= `EBPM_RST_THRESH;
        end else if (init_cnt_reg == 2'h0) begin
            thresh_reg <= bus_mode ? `EBPM_THR_REDUCED : `EBPM_THR_FULL;
        end else if (wr_go && avs_address == `EBPM_OFF_THRESH) begin
            thresh_reg <= avs_writedata[1:0];
        end
    end
    assign port_c_low_thresh = thresh_reg[`EBPM_THR_C_BIT];
    assign port_d_low_thresh = thresh_reg[`EBPM_THR_D_BIT];

    // Wait for the synchroniser to fill before sampling the strap
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            init_cnt_reg            <= 2'h0;
            init_done_reg           <= 1'b0;
            oscillator_select_input <= 1'b0;
            port_e_pin7_pullup      <= 1'b1;
        end else if (!init_done_reg) begin
            if (init_cnt_reg == `EBPM_INIT_LATCH) begin
                oscillator_select_input <= e7_sync;
                init_done_reg           <= 1'b1;
                port_e_pin7_pullup      <= 1'b0;
            end else begin
                init_cnt_reg <= init_cnt_reg + 2'h1;
            end
        end
    end

    // Toggles every clk: clk/2, twice the bus rate
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dclk_reg <= 1'b0;
        end else begin
            dclk_reg <= ~dclk_reg;
        end
    end

    wire dclk_on = init_done_reg & (emul_mode | e7_ctrl_reg[`EBPM_E7_CLKEN_BIT]);

    reg [7:0] pa_out_next;
    reg [7:0] pa_oe_next;
    reg [7:0] pb_out_next;
    reg [7:0] pb_oe_next;
    reg [7:0] pc_out_next;
    reg [7:0] pc_oe_next;
    reg [7:0] pd_out_next;
    reg [7:0] pd_oe_next;
    reg       pe_out_next;
    reg       pe_oe_next;

    always @* begin
        pa_out_next = dout_reg[7:0];
        pa_oe_next  = ~dir_reg[7:0];
        pb_out_next = dout_reg[15:8];
        pb_oe_next  = ~dir_reg[15:8];
        pc_out_next = dout_reg[23:16];
        pc_oe_next  = ~dir_reg[23:16];
        pd_out_next = dout_reg[31:24];
        pd_oe_next  = ~dir_reg[31:24];
        if (bus_mode) begin
            pa_oe_next  = 8'h00;
            pa_out_next = vis_now ? visibility_read_data[15:8] : ext_bus_addr[15:8];
            pb_oe_next  = 8'h00;
            pb_out_next[7:1] = vis_now ? visibility_read_data[7:1] : ext_bus_addr[7:1];
            if (emul_mode) begin
                pb_out_next[0] = visibility_phase ? visibility_read_data[0] : ext_bus_addr[0];
            end else if (e7_ctrl_reg[`EBPM_E7_UDSSEL_BIT]) begin
                pb_out_next[0] = upper_data_strobe_n;
            end else begin
                pb_out_next[0] = ext_bus_addr[0];
            end
            pc_out_next = ext_bus_wdata[15:8];
            pc_oe_next  = {8{~ext_bus_write}};
            pd_out_next = ext_bus_wdata[7:0];
            pd_oe_next  = {8{~ext_bus_write}};
        end
        if (!init_done_reg) begin
            pe_out_next = 1'b0;
            pe_oe_next  = 1'b1;
        end else if (dclk_on) begin
            pe_out_next = ~dclk_reg;
            pe_oe_next  = 1'b0;
        end else begin
            pe_out_next = e7_ctrl_reg[`EBPM_E7_OUT_BIT];
            pe_oe_next  = ~e7_ctrl_reg[`EBPM_E7_DIR_BIT];
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_a_pins_out  <= 8'h00;
            port_a_pins_oe_n <= 8'hff;
            port_b_pins_out  <= 8'h00;
            port_b_pins_oe_n <= 8'hff;
            port_c_pins_out  <= 8'h00;
            port_c_pins_oe_n <= 8'hff;
            port_d_pins_out  <= 8'h00;
            port_d_pins_oe_n <= 8'hff;
            port_e_pin7_out  <= 1'b0;
            port_e_pin7_oe_n <= 1'b1;
        end else begin
            port_a_pins_out  <= pa_out_next;
            port_a_pins_oe_n <= pa_oe_next;
            port_b_pins_out  <= pb_out_next;
            port_b_pins_oe_n <= pb_oe_next;
            port_c_pins_out  <= pc_out_next;
            port_c_pins_oe_n <= pc_oe_next;
            port_d_pins_out  <= pd_out_next;
            port_d_pins_oe_n <= pd_oe_next;
            port_e_pin7_out  <= pe_out_next;
            port_e_pin7_oe_n <= pe_oe_next;
        end
    end

    // Read data taken from the synchronised data pins
    assign ext_bus_rdata = {pin_vec[23:16], pin_vec[31:24]};

    reg [31:0] rd_next;
    always @* begin
        rd_next = 32'h00000000;
        if (avs_address == `EBPM_OFF_DATA_A) begin
            rd_next[7:0] = gpio_view(dout_reg[7:0], dir_reg[7:0], pin_vec[7:0]);
        end else if (avs_address == `EBPM_OFF_DIR_A) begin
            rd_next[7:0] = dir_reg[7:0];
        end else if (avs_address == `EBPM_OFF_DATA_B) begin
            rd_next[7:0] = gpio_view(dout_reg[15:8], dir_reg[15:8], pin_vec[15:8]);
        end else if (avs_address == `EBPM_OFF_DIR_B) begin
            rd_next[7:0] = dir_reg[15:8];
        end else if (avs_address == `EBPM_OFF_DATA_C) begin
            rd_next[7:0] = gpio_view(dout_reg[23:16], dir_reg[23:16], pin_vec[23:16]);
        end else if (avs_address == `EBPM_OFF_DIR_C) begin
            rd_next[7:0] = dir_reg[23:16];
        end else if (avs_address == `EBPM_OFF_DATA_D) begin
            rd_next[7:0] = gpio_view(dout_reg[31:24], dir_reg[31:24], pin_vec[31:24]);
        end else if (avs_address == `EBPM_OFF_DIR_D) begin
            rd_next[7:0] = dir_reg[31:24];
        end else if (avs_address == `EBPM_OFF_E7_CTRL) begin
            rd_next[3:0] = e7_ctrl_reg;
            rd_next[`EBPM_E7_PIN_BIT] = e7_sync;
        end else if (avs_address == `EBPM_OFF_THRESH) begin
            rd_next[1:0] = thresh_reg;
        end else if (avs_address == `EBPM_OFF_STATUS) begin
            rd_next[4:0] = {init_done_reg, dclk_on, oscillator_select_input, mcu_mode};
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read & ~ack_reg) begin
            avs_readdata <= rd_next;
        end
    end

endmodule

// File: dv/ebpm_pin_mux_monitor.sv
// Purpose: Port checker for the external bus pin multiplexer
// Assumes: Mode 01 expanded, 10 emulation; pull-up high marks init running
// Notes:   Pin outputs are one clk behind the core inputs
`timescale 1ns/1ps
module ebpm_pin_mux_mon (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [1:0]  mcu_mode,
    input wire logic [15:0] ext_bus_addr,
    input wire logic [15:0] ext_bus_wdata,
    input wire logic        ext_bus_write,
    input wire logic [15:0] visibility_read_data,
    input wire logic        visibility_phase,
    input wire logic [7:0]  port_a_pins_out,
    input wire logic [7:0]  port_a_pins_oe_n,
    input wire logic [7:0]  port_b_pins_out,
    input wire logic [7:0]  port_b_pins_oe_n,
    input wire logic [7:0]  port_c_pins_out,
    input wire logic [7:0]  port_c_pins_oe_n,
    input wire logic [7:0]  port_d_pins_out,
    input wire logic [7:0]  port_d_pins_oe_n,
    input wire logic        port_e_pin7_out,
    input wire logic        port_e_pin7_oe_n,
    input wire logic        port_e_pin7_pullup,
    input wire logic        port_c_low_thresh,
    input wire logic        port_d_low_thresh,
    input wire logic        oscillator_select_input
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_exp_addr_out: assert property ($past(nrst) && $past(mcu_mode) == 2'b01 |->
        {port_a_pins_out, port_b_pins_out[7:1]} == $past(ext_bus_addr[15:1]) && port_a_pins_oe_n == 8'h00)
        else $error("address not on ports A and B");
    chk_emu_vis_mux: assert property ($past(nrst) && $past(mcu_mode) == 2'b10 |->
        {port_a_pins_out, port_b_pins_out} == ($past(visibility_phase) ? $past(visibility_read_data)
        : $past(ext_bus_addr))) else $error("emulation address or visibility wrong");
    chk_data_drive: assert property ($past(nrst) && $past(^mcu_mode) && $past(ext_bus_write) |->
        {port_c_pins_out, port_d_pins_out} == $past(ext_bus_wdata) && port_c_pins_oe_n == 8'h00)
        else $error("write data not driven");
    chk_data_release: assert property ($past(nrst) && $past(^mcu_mode) && !$past(ext_bus_write) |->
        {port_c_pins_oe_n, port_d_pins_oe_n} == 16'hffff) else $error("data ports not released");
    chk_thresh_reset: assert property (port_e_pin7_pullup && $past(nrst, 2) && $stable(mcu_mode) |->
        {port_c_low_thresh, port_d_low_thresh} == {2{^mcu_mode}}) else $error("threshold reset value wrong");
    chk_osc_held: assert property (!port_e_pin7_pullup && !$past(port_e_pin7_pullup) |->
        $stable(oscillator_select_input)) else $error("oscillator select changed");
    chk_strap_free: assert property (port_e_pin7_pullup |-> port_e_pin7_oe_n)
        else $error("strap pin driven during init");
    chk_dbl_clock: assert property ($past(mcu_mode, 2) == 2'b10 && $past(mcu_mode) == 2'b10 &&
        !$past(port_e_pin7_oe_n) |-> !port_e_pin7_oe_n && port_e_pin7_out != $past(port_e_pin7_out))
        else $error("double rate clock not toggling");
endmodule
bind ebpm_pin_mux ebpm_pin_mux_mon u_mon (.*);

// File: dv/ebpm_ext_mem.sv
// Purpose: External memory on the expanded data bus
// Assumes: Always selected, answers in the same cycle
// Notes:   Sixteen words indexed by address bits 3:0
`timescale 1ns/1ps
module ebpm_ext_mem (
    input  wire logic       clk,
    input  wire logic [7:0] addr_lo,
    input  wire logic [7:0] c_out,
    input  wire logic [7:0] c_oe_n,
    input  wire logic [7:0] d_out,
    input  wire logic [7:0] d_oe_n,
    output logic      [7:0] c_pin,
    output logic      [7:0] d_pin
);
    logic [15:0] mem [16];
    logic [15:0] rd;
    initial for (int i = 0; i < 16; i++) mem[i] = 16'h0f0f ^ 16'(i);
    assign rd = mem[addr_lo[3:0]];
    // Store while the core drives both data ports
    always @(posedge clk) begin
        if ({c_oe_n, d_oe_n} == 16'h0000) begin
            mem[addr_lo[3:0]] <= {c_out, d_out};
        end
    end
    // Answer only on bits the core has released
    assign c_pin = (c_out & ~c_oe_n) | (rd[15:8] & c_oe_n);
    assign d_pin = (d_out & ~d_oe_n) | (rd[7:0] & d_oe_n);
endmodule

// File: dv/ebpm_pin_mux_tb.sv
// Purpose: Self-checking bench for the pin multiplexer
// Assumes: Master waits for waitrequest low, however long it takes
// Notes:   Strap level comes from the bench when E7 is released
`timescale 1ns/1ps
`include "ebpm_defines.vh"
module ebpm_pin_mux_tb;
    logic        clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, strap = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0]  avs_byteenable = 4'h1;
    logic        avs_waitrequest, ext_bus_write = 1'b0, upper_data_strobe_n = 1'b1, visibility_phase = 1'b0;
    logic [1:0]  mcu_mode = 2'b00;
    logic [15:0] ext_bus_addr = 16'h0, ext_bus_wdata = 16'h0, visibility_read_data = 16'h0, ext_bus_rdata;
    logic [7:0]  a_drv = 8'h00, b_drv = 8'h00, port_a_pins_in, port_b_pins_in, port_c_pins_in, port_d_pins_in;
    logic [7:0]  port_a_pins_out, port_a_pins_oe_n, port_b_pins_out, port_b_pins_oe_n;
    logic [7:0]  port_c_pins_out, port_c_pins_oe_n, port_d_pins_out, port_d_pins_oe_n;
    logic        port_e_pin7_in, port_e_pin7_out, port_e_pin7_oe_n, port_e_pin7_pullup;
    logic        port_c_low_thresh, port_d_low_thresh, oscillator_select_input;
    int          error_cnt = 0, samples_checked = 0;
    always #4 clk = ~clk;
    assign port_a_pins_in = (port_a_pins_out & ~port_a_pins_oe_n) | (a_drv & port_a_pins_oe_n);
    assign port_b_pins_in = (port_b_pins_out & ~port_b_pins_oe_n) | (b_drv & port_b_pins_oe_n);
    assign port_e_pin7_in = port_e_pin7_oe_n ? strap : port_e_pin7_out;
    ebpm_pin_mux u_dut (.*);
    ebpm_ext_mem u_mem (.clk(clk), .addr_lo(port_b_pins_out), .c_out(port_c_pins_out), .c_oe_n(port_c_pins_oe_n),
        .d_out(port_d_pins_out), .d_oe_n(port_d_pins_oe_n), .c_pin(port_c_pins_in), .d_pin(port_d_pins_in));
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, wd};
        @(posedge clk);
        // No local limit: only the watchdog ends a hung wait
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task rdc(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 8'h00, x);
        chk(x, e);
    endtask
    task do_reset(input logic [1:0] m, input logic s);
        @(posedge clk);
        nrst <= 1'b0;
        mcu_mode <= m;
        strap <= s;
        repeat (3) @(posedge clk);
        chk({30'h0, port_e_pin7_pullup, port_e_pin7_oe_n}, 32'h3);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        chk({30'h0, port_e_pin7_pullup, oscillator_select_input}, {31'h0, s});
    endtask
    task chk_clk;
        logic x;
        repeat (2) @(posedge clk);
        x = port_e_pin7_out;
        @(posedge clk);
        chk({30'h0, port_e_pin7_out ^ x, port_e_pin7_oe_n}, 32'h2);
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        error_cnt++;
        end_sim;
    end
    initial begin
        do_reset(2'b00, 1'b1);
        rdc(`EBPM_OFF_STATUS, 32'h14);
        rdc(`EBPM_OFF_THRESH, 32'h0);
        strap <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(6'(8 * i + 4), 8'hff);
            wr(6'(8 * i), 8'(8'h11 * (i + 1)));
        end
        // Last data write lands at the answer edge; pins register one edge later
        repeat (2) @(posedge clk);
        chk({port_a_pins_out, port_b_pins_out, port_c_pins_out, port_d_pins_out}, 32'h11223344);
        chk({port_a_pins_oe_n, port_b_pins_oe_n, port_c_pins_oe_n, port_d_pins_oe_n}, 32'h0);
        wr(`EBPM_OFF_DIR_B, 8'h00);
        b_drv <= 8'h3d;
        repeat (3) @(posedge clk);
        rdc(`EBPM_OFF_DATA_B, 32'h3d);
        rdc(6'h3c, 32'h0);
        wr(`EBPM_OFF_STATUS, 8'h00);
        rdc(`EBPM_OFF_STATUS, 32'h14);
        wr(`EBPM_OFF_THRESH, 8'h01);
        rdc(`EBPM_OFF_THRESH, 32'h1);
        chk({30'h0, port_d_low_thresh, port_c_low_thresh}, 32'h1);
        wr(`EBPM_OFF_E7_CTRL, 8'h04);
        chk_clk;
        $display("normal mode test done");
        do_reset(2'b01, 1'b0);
        rdc(`EBPM_OFF_STATUS, 32'h11);
        rdc(`EBPM_OFF_THRESH, 32'h3);
        chk({31'h0, port_e_pin7_oe_n}, 32'h1);
        ext_bus_addr <= 16'h1235;
        ext_bus_wdata <= 16'hbeef;
        ext_bus_write <= 1'b1;
        repeat (2) @(posedge clk);
        ext_bus_write <= 1'b0;
        repeat (5) @(posedge clk);
        chk({16'h0, ext_bus_rdata}, 32'hbeef);
        upper_data_strobe_n <= 1'b0;
        wr(`EBPM_OFF_E7_CTRL, 8'h08);
        repeat (2) @(posedge clk);
        chk({31'h0, port_b_pins_out[0]}, 32'h0);
        wr(`EBPM_OFF_E7_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        chk({31'h0, port_b_pins_out[0]}, 32'h1);
        $display("expanded mode test done");
        do_reset(2'b10, 1'b1);
        rdc(`EBPM_OFF_STATUS, 32'h1e);
        rdc(`EBPM_OFF_THRESH, 32'h3);
        visibility_read_data <= 16'h9669;
        visibility_phase <= 1'b1;
        repeat (2) @(posedge clk);
        chk({port_a_pins_out, port_b_pins_out}, 32'h9669);
        visibility_phase <= 1'b0;
        repeat (2) @(posedge clk);
        chk({port_a_pins_out, port_b_pins_out}, 32'h1235);
        chk_clk;
        $display("emulation mode test done");
        end_sim;
    end
endmodule
